// ---- ddr_sram_core.v ----
// Purpose: Write data path with byte-lane masking of a two-word burst DDR SRAM.
// Assumes: Pin clocks are slow against pclk and are sampled as ordinary inputs.
// Notes:   Software reaches control, status and a peek window over APB.
//
// Notes on behaviour
// - 18-bit, both selects low: store all bits.
// - 18-bit, select 0 only: store bits 8:0.
// - 18-bit, select 1 only: store bits 17:9.
// - All selects high: nothing written.
// - 36-bit, all four low: store everything.
// - 36-bit, each select gates its nine bits.
// - Selects sampled per half, applied per half.
// - Powers up deselected, outputs tristated.
// - Write data taken on both input clock rises.
// - Read data on output clocks, else input clocks.
// - First word latched address, second burst address.
// - Timing counted from load cycle t.
// - Second address inverts the address LSB.
`timescale 1ns/10ps
`default_nettype none
`include "ddr_sram_map.vh"

module ddr_sram_core #(
	parameter DATA_W = 18,
	parameter ADDR_W = 4
) (
	input  wire                    pclk,
	input  wire                    presetn,
	input  wire                    psel,
	input  wire                    penable,
	input  wire                    pwrite,
	input  wire [11:0]             paddr,
	input  wire [31:0]             pwdata,
	output wire [31:0]             prdata,
	output wire                    pready,
	output wire                    pslverr,
	input  wire                    k_clk,
	input  wire                    k_clk_n,
	input  wire                    c_clk,
	input  wire                    c_clk_n,
	input  wire                    load_strobe_n,
	input  wire                    read_write,
	input  wire [ADDR_W-1:0]       addr,
	input  wire [DATA_W-1:0]       data_in,
	input  wire [DATA_W/9-1:0]     byte_lane_select_n,
	output wire [DATA_W-1:0]       data_out,
	output wire                    data_oe
);

	localparam LANES  = DATA_W / `LANE_BITS;
	localparam DEPTH  = 1 << ADDR_W;
	localparam SYNC_W = 6 + ADDR_W + DATA_W + LANES;
	localparam [31:0] CTRL_RST_WORD = `CTRL_RESET;

	// Read sequencing states.
	localparam RD_IDLE   = 2'b00;
	localparam RD_SECOND = 2'b01;
	localparam RD_TAIL   = 2'b10;

	wire [SYNC_W-1:0] pins_s;
	wire              k_s;
	wire              kn_s;
	wire              c_s;
	wire              cn_s;
	wire              load_n_s;
	wire              rw_s;
	wire [ADDR_W-1:0] addr_s;
	wire [DATA_W-1:0] din_s;
	wire [LANES-1:0]  lanes_s;

	// All pins pass two flip-flops before any logic looks at them.
	pin_sync #(
		.WIDTH (SYNC_W)
	) u_pin_sync (
		.pclk     (pclk),
		.presetn  (presetn),
		.async_in ({k_clk, k_clk_n, c_clk, c_clk_n, load_strobe_n, read_write,
		            addr, data_in, byte_lane_select_n}),
		.sync_out (pins_s)
	);

	assign {k_s, kn_s, c_s, cn_s, load_n_s, rw_s, addr_s, din_s, lanes_s} = pins_s;

	reg                k_prev_ff;
	reg                kn_prev_ff;
	reg                c_prev_ff;
	reg                cn_prev_ff;
	reg                strap_done_ff;
	reg [1:0]          strap_age_ff;
	reg                single_clk_ff;
	reg                enable_ff;
	reg [ADDR_W-1:0]   peek_addr_ff;
	reg [15:0]         wr_count_ff;
	reg [31:0]         prdata_ff;
	reg [DATA_W-1:0]   mem [0:DEPTH-1];

	wire k_rise  = k_s & ~k_prev_ff;
	wire kn_rise = kn_s & ~kn_prev_ff;
	wire c_rise  = c_s & ~c_prev_ff;
	wire cn_rise = cn_s & ~cn_prev_ff;

	// Edge memory for the sampled pin clocks.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			k_prev_ff  <= 1'b0;
			kn_prev_ff <= 1'b0;
			c_prev_ff  <= 1'b0;
			cn_prev_ff <= 1'b0;
		end else begin
			k_prev_ff  <= k_s;
			kn_prev_ff <= kn_s;
			c_prev_ff  <= c_s;
			cn_prev_ff <= cn_s;
		end
	end

	// The clock mode strap is caught once, after the synchroniser holds real pin values.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			strap_done_ff <= 1'b0;
			strap_age_ff  <= 2'h0;
			single_clk_ff <= 1'b0;
		end else if (!strap_done_ff) begin
			strap_age_ff <= strap_age_ff + 2'h1;
			if (strap_age_ff == 2'h2) begin
				strap_done_ff <= 1'b1;
				single_clk_ff <= c_s & cn_s;
			end
		end
	end

	// Output launch edges follow the output clocks, or the input clocks in single mode.
	wire out_rise   = single_clk_ff ? k_rise : c_rise;
	wire out_n_rise = single_clk_ff ? kn_rise : cn_rise;

	// A load is seen only on a positive input clock rise while enabled.
	wire load_now = enable_ff & strap_done_ff & k_rise & ~load_n_s;
	wire load_wr  = load_now & ~rw_s;
	wire load_rd  = load_now & rw_s;

	reg                wr_wait1_ff;
	reg                wr_wait2_ff;
	reg                commit_ff;
	reg [ADDR_W-1:0]   load_addr_ff;
	reg [ADDR_W-1:0]   burst_addr_ff;
	reg [DATA_W-1:0]   half1_data_ff;
	reg [DATA_W-1:0]   half2_data_ff;
	reg [LANES-1:0]    half1_lanes_ff;
	reg [LANES-1:0]    half2_lanes_ff;

	// Second burst address flips only the least significant bit.
	wire [ADDR_W-1:0] burst_second_address = burst_addr_ff ^ {{(ADDR_W-1){1'b0}}, 1'b1};
	wire [ADDR_W-1:0] burst_first_address  = burst_addr_ff;

	// Write sequencing: load, first half on the next K rise, second on K-bar.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wr_wait1_ff    <= 1'b0;
			wr_wait2_ff    <= 1'b0;
			commit_ff      <= 1'b0;
			load_addr_ff   <= {ADDR_W{1'b0}};
			burst_addr_ff  <= {ADDR_W{1'b0}};
			half1_data_ff  <= {DATA_W{1'b0}};
			half2_data_ff  <= {DATA_W{1'b0}};
			half1_lanes_ff <= {LANES{1'b1}};
			half2_lanes_ff <= {LANES{1'b1}};
		end else begin
			commit_ff <= 1'b0;
			// First half and its own selects are taken at the next K rise.
			if (k_rise && wr_wait1_ff) begin
				half1_data_ff  <= din_s;
				half1_lanes_ff <= lanes_s;
				burst_addr_ff  <= load_addr_ff;
				wr_wait2_ff    <= 1'b1;
			end
			// Second half and its own selects are taken at the K-bar rise.
			if (kn_rise && wr_wait2_ff) begin
				half2_data_ff  <= din_s;
				half2_lanes_ff <= lanes_s;
				wr_wait2_ff    <= 1'b0;
				commit_ff      <= 1'b1;
			end
			// A new load may coincide with the first half of the previous write.
			if (k_rise) begin
				wr_wait1_ff <= load_wr;
			end
			if (load_wr) begin
				load_addr_ff <= addr_s;
			end
		end
	end

	wire [DATA_W-1:0] merged1;
	wire [DATA_W-1:0] merged2;
	wire              any1;
	wire              any2;

	// Lane masking of the first half against the stored word.
	lane_merge #(
		.LANES (LANES)
	) u_merge_first (
		.old_word   (mem[burst_first_address]),
		.new_word   (half1_data_ff),
		.lane_sel_n (half1_lanes_ff),
		.merged     (merged1),
		.any_lane   (any1)
	);

	// Lane masking of the second half against the stored word.
	lane_merge #(
		.LANES (LANES)
	) u_merge_second (
		.old_word   (mem[burst_second_address]),
		.new_word   (half2_data_ff),
		.lane_sel_n (half2_lanes_ff),
		.merged     (merged2),
		.any_lane   (any2)
	);

	// Both halves go to the array together; a half with no lane selected is skipped.
	always @(posedge pclk) begin
		if (commit_ff && any1) begin
			mem[burst_first_address] <= merged1;
		end
		if (commit_ff && any2) begin
			mem[burst_second_address] <= merged2;
		end
	end

	reg [1:0]          rd_state_ff;
	reg                rd_pend_ff;
	reg [ADDR_W-1:0]   rd_addr_ff;
	reg [ADDR_W-1:0]   rd_pend_addr_ff;
	reg [DATA_W-1:0]   dout_ff;
	reg                oe_ff;

	// Read sequencing: first word on the negative output rise, second on the positive.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_state_ff     <= RD_IDLE;
			rd_pend_ff      <= 1'b0;
			rd_addr_ff      <= {ADDR_W{1'b0}};
			rd_pend_addr_ff <= {ADDR_W{1'b0}};
			dout_ff         <= {DATA_W{1'b0}};
			oe_ff           <= 1'b0;
		end else begin
			if (load_rd) begin
				rd_pend_ff      <= 1'b1;
				rd_pend_addr_ff <= addr_s;
			end else if (out_n_rise && rd_pend_ff && rd_state_ff != RD_SECOND) begin
				rd_pend_ff <= 1'b0;
			end
			case (rd_state_ff)
				RD_IDLE, RD_TAIL: begin
					if (out_n_rise && rd_pend_ff) begin
						dout_ff     <= mem[rd_pend_addr_ff];
						rd_addr_ff  <= rd_pend_addr_ff;
						oe_ff       <= 1'b1;
						rd_state_ff <= RD_SECOND;
					end else if (out_n_rise && rd_state_ff == RD_TAIL) begin
						oe_ff       <= 1'b0;
						rd_state_ff <= RD_IDLE;
					end
				end
				RD_SECOND: begin
					if (out_rise) begin
						dout_ff     <= mem[rd_addr_ff ^ {{(ADDR_W-1){1'b0}}, 1'b1}];
						rd_state_ff <= RD_TAIL;
					end
				end
				default: begin
					rd_state_ff <= RD_IDLE;
					oe_ff       <= 1'b0;
				end
			endcase
		end
	end

	assign data_out = dout_ff;
	assign data_oe  = oe_ff;

	// APB decode; every access finishes in its first access cycle.
	wire apb_setup = psel & ~penable;
	wire apb_write = psel & penable & pwrite;
	wire hit_ctrl  = (paddr == `CTRL_OFFSET);
	wire hit_stat  = (paddr == `STATUS_OFFSET);
	wire hit_paddr = (paddr == `PEEK_ADDR_OFFSET);
	wire hit_pdata = (paddr == `PEEK_DATA_OFFSET);
	wire hit_count = (paddr == `WR_COUNT_OFFSET);
	wire hit_any   = hit_ctrl | hit_stat | hit_paddr | hit_pdata | hit_count;

	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~hit_any;

	// Software writes: enable and the peek address.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			enable_ff    <= CTRL_RST_WORD[`CTRL_ENABLE_BIT];
			peek_addr_ff <= {ADDR_W{1'b0}};
		end else if (apb_write) begin
			if (hit_ctrl) begin
				enable_ff <= pwdata[`CTRL_ENABLE_BIT];
			end
			if (hit_paddr) begin
				peek_addr_ff <= pwdata[ADDR_W-1:0];
			end
		end
	end

	// Counts burst commits that changed at least one lane; writing clears it unless a commit lands in the same cycle.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wr_count_ff <= 16'h0000;
		end else if (commit_ff && (any1 || any2)) begin
			wr_count_ff <= wr_count_ff + 16'h0001;
		end else if (apb_write && hit_count) begin
			wr_count_ff <= 16'h0000;
		end
	end

	wire [31:0] status_word;

	// Live device state as seen by software.
	assign status_word = {27'h0000000, oe_ff, (rd_state_ff != RD_IDLE) | rd_pend_ff,
		wr_wait1_ff | wr_wait2_ff | commit_ff, (LANES == 4), single_clk_ff};

	// Read data is captured during the setup cycle and held through access.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_ff <= 32'h0000_0000;
		end else if (apb_setup && !pwrite) begin
			if (hit_ctrl) begin
				prdata_ff <= {31'h0000_0000, enable_ff};
			end else if (hit_stat) begin
				prdata_ff <= status_word;
			end else if (hit_paddr) begin
				prdata_ff <= {{(32-ADDR_W){1'b0}}, peek_addr_ff};
			end else if (hit_pdata) begin
				prdata_ff <= {{(32-DATA_W){1'b0}}, mem[peek_addr_ff]};
			end else if (hit_count) begin
				prdata_ff <= {16'h0000, wr_count_ff};
			end else begin
				prdata_ff <= 32'h0000_0000;
			end
		end
	end

	assign prdata = prdata_ff;

endmodule
`default_nettype wire

// ---- ddr_sram_map.vh ----
// Purpose: Register offsets, field positions and reset values of the SRAM write path.
// Assumes: APB byte addresses, one aligned 32-bit word per register.
// Notes:   Definitions only.
`ifndef DDR_SRAM_MAP_VH
`define DDR_SRAM_MAP_VH

// Register byte offsets.
`define CTRL_OFFSET        12'h000
`define STATUS_OFFSET      12'h004
`define PEEK_ADDR_OFFSET   12'h008
`define PEEK_DATA_OFFSET   12'h00C
`define WR_COUNT_OFFSET    12'h010

// Control register fields and reset value.
`define CTRL_ENABLE_BIT    0
`define CTRL_RESET         32'h0000_0001

// Status register fields.
`define STAT_SINGLE_BIT    0
`define STAT_WIDE_BIT      1
`define STAT_WR_BUSY_BIT   2
`define STAT_RD_BUSY_BIT   3
`define STAT_OE_BIT        4

// Width of one byte lane including its parity bit.
`define LANE_BITS          9

`endif

// ---- lane_merge.v ----
// Purpose: Merges new write data into a stored word, lane by lane.
// Assumes: Lane selects are active low, one per nine data bits.
// Notes:   A lane whose select is high keeps the stored bits.
`timescale 1ns/10ps
`default_nettype none
`include "ddr_sram_map.vh"

module lane_merge #(
	parameter LANES = 2
) (
	input  wire [LANES*`LANE_BITS-1:0] old_word,
	input  wire [LANES*`LANE_BITS-1:0] new_word,
	input  wire [LANES-1:0]            lane_sel_n,
	output wire [LANES*`LANE_BITS-1:0] merged,
	output wire                        any_lane
);

	genvar i;

	// Each lane takes new data only when its select is low.
	generate
		for (i = 0; i < LANES; i = i + 1) begin : g_lane
			assign merged[i*`LANE_BITS +: `LANE_BITS] = lane_sel_n[i] ?
				old_word[i*`LANE_BITS +: `LANE_BITS] :
				new_word[i*`LANE_BITS +: `LANE_BITS];
		end
	endgenerate

	// No write at all when every select is high.
	assign any_lane = ~&lane_sel_n;

endmodule
`default_nettype wire

// ---- pin_sync.v ----
// Purpose: Two-stage synchroniser for a group of pin inputs.
// Assumes: Inputs are asynchronous to pclk.
// Notes:   Only the second stage is visible outside.
`timescale 1ns/10ps
`default_nettype none

module pin_sync #(
	parameter WIDTH = 1
) (
	input  wire             pclk,
	input  wire             presetn,
	input  wire [WIDTH-1:0] async_in,
	output wire [WIDTH-1:0] sync_out
);

	reg [WIDTH-1:0] meta_ff;
	reg [WIDTH-1:0] stable_ff;

	// The first stage feeds only the second stage.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_ff   <= {WIDTH{1'b0}};
			stable_ff <= {WIDTH{1'b0}};
		end else begin
			meta_ff   <= async_in;
			stable_ff <= meta_ff;
		end
	end

	assign sync_out = stable_ff;

endmodule
`default_nettype wire

// ---- sram_ctrl_model.sv ----
// Purpose: Memory controller model driving the SRAM pins.
// Assumes: 18-bit organisation, each pin clock phase lasts 8 pclk.
// Notes:   Clocks stand high between bursts; released data is inverted.
`timescale 1ns/10ps
`default_nettype none
module sram_ctrl_model (
	input  wire logic        pclk,
	output logic             k_clk,
	output logic             k_clk_n,
	output logic             c_clk,
	output logic             c_clk_n,
	output logic             load_strobe_n,
	output logic             read_write,
	output logic [3:0]       addr,
	output logic [17:0]      data_in,
	output logic [1:0]       byte_lane_select_n,
	input  wire logic [17:0] data_out,
	input  wire logic        data_oe
);
	// Clocks parked high, output clocks tied high as a strap.
	initial begin
		k_clk = 1'b1;
		k_clk_n = 1'b1;
		c_clk = 1'b1;
		c_clk_n = 1'b1;
		load_strobe_n = 1'b1;
		read_write = 1'b1;
		addr = 4'h0;
		data_in = 18'h00000;
		byte_lane_select_n = 2'h3;
	end
	// Waits a number of pclk edges.
	task automatic ph(input integer n);
		repeat (n) @(posedge pclk);
	endtask
	// One write: load, first half at next k rise, second at next k_n rise.
	task automatic burst(input [3:0] a, input [17:0] d1, input [1:0] s1,
		input [17:0] d2, input [1:0] s2);
		@(posedge pclk);
		k_clk <= 1'b0;
		load_strobe_n <= 1'b0;
		read_write <= 1'b0;
		addr <= a;
		ph(8);
		k_clk <= 1'b1;
		k_clk_n <= 1'b0;
		ph(4);
		load_strobe_n <= 1'b1;
		addr <= ~a;
		data_in <= d1;
		byte_lane_select_n <= s1;
		ph(4);
		k_clk <= 1'b0;
		k_clk_n <= 1'b1;
		ph(8);
		k_clk <= 1'b1;
		k_clk_n <= 1'b0;
		ph(4);
		data_in <= d2;
		byte_lane_select_n <= s2;
		ph(4);
		k_clk <= 1'b0;
		k_clk_n <= 1'b1;
		ph(4);
		data_in <= ~d2;
		byte_lane_select_n <= ~s2;
		ph(4);
		k_clk <= 1'b1;
		ph(8);
	endtask
	// One read in single-clock mode; each word is sampled while it stands.
	task automatic fetch(input [3:0] a, output [17:0] q1, output o1, output [17:0] q2,
		output o2, output o3);
		@(posedge pclk);
		k_clk <= 1'b0;
		load_strobe_n <= 1'b0;
		read_write <= 1'b1;
		addr <= a;
		ph(8);
		k_clk <= 1'b1;
		k_clk_n <= 1'b0;
		ph(4);
		load_strobe_n <= 1'b1;
		addr <= ~a;
		ph(4);
		k_clk <= 1'b0;
		k_clk_n <= 1'b1;
		ph(8);
		q1 = data_out;
		o1 = data_oe;
		k_clk <= 1'b1;
		k_clk_n <= 1'b0;
		ph(8);
		q2 = data_out;
		o2 = data_oe;
		k_clk <= 1'b0;
		k_clk_n <= 1'b1;
		ph(8);
		o3 = data_oe;
		k_clk <= 1'b1;
		ph(8);
	endtask
endmodule
`default_nettype wire

// ---- sram_wr_monitor.sv ----
// Purpose: Port-level checks of the SRAM write path.
// Assumes: Pin clocks are slow against pclk.
// Notes:   Bound to every ddr_sram_core instance.
`timescale 1ns/10ps
`default_nettype none
module sram_wr_monitor #(
	parameter DATA_W = 18
) (
	input wire logic              pclk,
	input wire logic              presetn,
	input wire logic              k_clk,
	input wire logic              k_clk_n,
	input wire logic              c_clk,
	input wire logic              c_clk_n,
	input wire logic              load_strobe_n,
	input wire logic              read_write,
	input wire logic [DATA_W-1:0] data_out,
	input wire logic              data_oe
);
	logic       rd_seen_ff;
	logic [7:0] since_ff;
	logic [3:0] pins_ff;
	logic       pin_rise;
	// Any pin clock rise restarts the launch window.
	assign pin_rise = |({k_clk, k_clk_n, c_clk, c_clk_n} & ~pins_ff);
	// Remembers a read load and counts cycles since the last pin clock rise.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_seen_ff <= 1'b0;
			since_ff <= 8'h00;
			pins_ff <= 4'hF;
		end else begin
			pins_ff <= {k_clk, k_clk_n, c_clk, c_clk_n};
			if (!load_strobe_n && read_write)
				rd_seen_ff <= 1'b1;
			since_ff <= pin_rise ? 8'h00 : (since_ff == 8'hFF ? since_ff : since_ff + 8'h01);
		end
	end
	oe_before_read_a: assert property (@(posedge pclk) disable iff (!presetn)
		!rd_seen_ff |-> !data_oe) else $error("outputs driven before any read");
	out_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
		!rd_seen_ff |-> data_out == '0) else $error("read word moved before any read");
	launch_edge_a: assert property (@(posedge pclk) disable iff (!presetn)
		$changed(data_out) |-> since_ff <= 8'h06) else $error("read word off launch edge");
	oe_edge_a: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(data_oe) |-> since_ff <= 8'h06) else $error("output enable off launch edge");
	oe_with_data_a: assert property (@(posedge pclk) disable iff (!presetn)
		$changed(data_out) |-> data_oe) else $error("read word moved while outputs off");
	oe_fall_edge_a: assert property (@(posedge pclk) disable iff (!presetn)
		$fell(data_oe) |-> since_ff <= 8'h06) else $error("output enable fell off launch edge");
endmodule
bind ddr_sram_core sram_wr_monitor #(.DATA_W(DATA_W)) i_sram_wr_monitor (
	.pclk(pclk), .presetn(presetn), .k_clk(k_clk), .k_clk_n(k_clk_n), .c_clk(c_clk),
	.c_clk_n(c_clk_n), .load_strobe_n(load_strobe_n), .read_write(read_write),
	.data_out(data_out), .data_oe(data_oe));
`default_nettype wire

// ---- tb.sv ----
// Purpose: Self-checking bench of the SRAM write path, 18-bit organisation.
// Assumes: Array contents reached through the peek window over APB.
// Notes:   Random bursts with fixed seed plus corner cases.
`timescale 1ns/10ps
`default_nettype none
`include "ddr_sram_map.vh"
module tb;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, data_oe, k_clk, k_clk_n, c_clk, c_clk_n, load_strobe_n, read_write, e;
	logic [3:0] addr;
	logic [17:0] data_in, data_out, mem[16];
	logic [1:0] byte_lane_select_n;
	integer err_total = 0, checked = 0, cycles = 0, cnt = 0, en = 1, i, seed = 32'hfd5b3d1f;
	// Clock at 125 MHz and a hang limit.
	always #4 pclk = ~pclk;
	always @(posedge pclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			err_total = err_total + 1;
			end_of_test();
		end
	end
	ddr_sram_core #(.DATA_W(18), .ADDR_W(4)) i_ddr_sram_core (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .k_clk(k_clk), .k_clk_n(k_clk_n),
		.c_clk(c_clk), .c_clk_n(c_clk_n), .load_strobe_n(load_strobe_n),
		.read_write(read_write), .addr(addr), .data_in(data_in),
		.byte_lane_select_n(byte_lane_select_n), .data_out(data_out), .data_oe(data_oe));
	sram_ctrl_model i_sram_ctrl_model (.pclk(pclk), .k_clk(k_clk), .k_clk_n(k_clk_n),
		.c_clk(c_clk), .c_clk_n(c_clk_n), .load_strobe_n(load_strobe_n),
		.read_write(read_write), .addr(addr), .data_in(data_in),
		.byte_lane_select_n(byte_lane_select_n), .data_out(data_out), .data_oe(data_oe));
	// Compares and counts.
	task automatic check(input [31:0] seen, input [31:0] exp);
		checked = checked + 1;
		if (seen !== exp) begin
			err_total = err_total + 1;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// One APB transfer, held until pready is sampled high.
	task automatic apb(input w, input [11:0] a, input [31:0] wd);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rd = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Expected word after one masked half.
	function automatic [17:0] merge(input [17:0] o, input [17:0] n, input [1:0] s);
		merge = o;
		if (!s[0]) merge[8:0] = n[8:0];
		if (!s[1]) merge[17:9] = n[17:9];
	endfunction
	// Reads one array word through the peek window.
	task automatic peek(input [3:0] a);
		apb(1'b1, `PEEK_ADDR_OFFSET, {28'h0, a});
		apb(1'b0, `PEEK_DATA_OFFSET, 32'h0);
		check(rd & 32'h3FFFF, {14'h0, mem[a]});
	endtask
	// One burst, model update and peek of both words.
	task automatic wr(input [3:0] a, input [17:0] d1, input [1:0] s1, input [17:0] d2,
		input [1:0] s2);
		i_sram_ctrl_model.burst(a, d1, s1, d2, s2);
		if (en) begin
			mem[a] = merge(mem[a], d1, s1);
			mem[a ^ 4'h1] = merge(mem[a ^ 4'h1], d2, s2);
			if (s1 != 2'h3 || s2 != 2'h3) cnt = cnt + 1;
		end
		peek(a);
		peek(a ^ 4'h1);
	endtask
	// One read burst; both words and the output enable are compared.
	task automatic rdb(input [3:0] a);
		logic [17:0] q1, q2;
		logic o1, o2, o3;
		i_sram_ctrl_model.fetch(a, q1, o1, q2, o2, o3);
		check({14'h0, q1}, {14'h0, mem[a]});
		check({14'h0, q2}, {14'h0, mem[a ^ 4'h1]});
		check({29'h0, o1, o2, o3}, 32'h6);
	endtask
	// Prints the counts and the verdict, then stops.
	task automatic end_of_test();
		$display("checked=%0d err_total=%0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// Main sequence.
	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, `CTRL_OFFSET, 32'h0);
		check(rd, `CTRL_RESET);
		apb(1'b0, `STATUS_OFFSET, 32'h0);
		check(rd & 32'h1F, 32'h1);
		apb(1'b0, 12'h020, 32'h0);
		check({31'h0, e}, 32'h1);
		apb(1'b1, `WR_COUNT_OFFSET, 32'h0);
		$display("test registers done");
		for (i = 0; i < 16; i = i + 2)
			wr(i[3:0], $random(seed), 2'h0, $random(seed), 2'h0);
		wr(4'h3, $random(seed), 2'h3, $random(seed), 2'h3);
		wr(4'h4, $random(seed), 2'h2, $random(seed), 2'h1);
		wr(4'h9, $random(seed), 2'h1, $random(seed), 2'h2);
		$display("test corners done");
		repeat (24)
			wr($random(seed), $random(seed), $random(seed), $random(seed), $random(seed));
		apb(1'b0, `WR_COUNT_OFFSET, 32'h0);
		check(rd & 32'hFFFF, cnt);
		$display("test random done");
		rdb(4'h4);
		repeat (4)
			rdb($random(seed));
		$display("test read done");
		apb(1'b1, `CTRL_OFFSET, 32'h0);
		en = 0;
		wr(4'h6, $random(seed), 2'h0, $random(seed), 2'h0);
		apb(1'b0, `WR_COUNT_OFFSET, 32'h0);
		check(rd & 32'hFFFF, cnt);
		$display("test disable done");
		end_of_test();
	end
endmodule
`default_nettype wire
